// ---- tts_pkg.sv ----
package tts_pkg;

  // bus geometry
  localparam int unsigned TTS_AXI_AW = 12;
  localparam int unsigned TTS_AXI_DW = 32;
  localparam int unsigned TTS_REG_W  = 8;
  localparam int unsigned TTS_CODE_W = 4;
  localparam int unsigned TTS_US_W   = 14;
  localparam int unsigned TTS_CYC_W  = 20;
  localparam int unsigned TTS_NSEG   = 4;

  // printed offsets are register indexes; byte address is four times the index
  localparam logic [7:0] TTS_IDX_CFG_THREE = 8'h62;
  localparam logic [7:0] TTS_IDX_CFG_FOUR  = 8'h63;
  localparam logic [TTS_AXI_AW-1:0] TTS_ADDR_CFG_THREE = {2'h0, TTS_IDX_CFG_THREE, 2'h0};
  localparam logic [TTS_AXI_AW-1:0] TTS_ADDR_CFG_FOUR  = {2'h0, TTS_IDX_CFG_FOUR, 2'h0};

  // field positions inside each config register
  localparam int unsigned TTS_HI_FIELD_LSB = 4;
  localparam int unsigned TTS_LO_FIELD_LSB = 0;

  // axi responses
  localparam logic [1:0] TTS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TTS_RESP_SLVERR = 2'h2;

  // reset values of bus-side state
  localparam logic [TTS_REG_W-1:0]  TTS_RDATA_RST = 8'h00;
  localparam logic [TTS_US_W-1:0]   TTS_US_RST    = 14'h0000;
  localparam logic [TTS_CYC_W-1:0]  TTS_CYC_RST   = 20'h00000;

  // clock: 8 ns period, cycles per microsecond derived from it
  localparam int unsigned TTS_CLK_PERIOD_NS = 8;
  localparam int unsigned TTS_CYC_PER_US    = 1000 / TTS_CLK_PERIOD_NS;

  // segment delta time in microseconds, indexed by the 4-bit code
  localparam logic [15:0][TTS_US_W-1:0] TTS_TIME_US = {
    14'd8000, 14'd6400, 14'd5200, 14'd4000,
    14'd3200, 14'd2400, 14'd2000, 14'd1400,
    14'd1200, 14'd1000, 14'd800,  14'd600,
    14'd400,  14'd300,  14'd200,  14'd100
  };

endpackage

// ---- tts_time_lut.sv ----
`timescale 1ns/1ps
module tts_time_lut
  import tts_pkg::*;
(
  input  wire logic [tts_pkg::TTS_CODE_W-1:0] code,
  output logic      [tts_pkg::TTS_US_W-1:0]   time_us,
  output logic      [tts_pkg::TTS_CYC_W-1:0]  time_cyc
);
  import tts_pkg::*;

  // pure table lookup, no state; product fits 20 bits (8000 * 125)
  always_comb begin
    time_us  = TTS_TIME_US[code];
    time_cyc = TTS_CYC_W'(time_us) * TTS_CYC_W'(TTS_CYC_PER_US);
  end

endmodule

// ---- tts_regs.sv ----
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module tts_regs
  import tts_pkg::*;
(
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [tts_pkg::TTS_AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [tts_pkg::TTS_AXI_DW-1:0]  s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [tts_pkg::TTS_AXI_AW-1:0]  s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [tts_pkg::TTS_AXI_DW-1:0]       s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  output logic [tts_pkg::TTS_US_W-1:0]         seg_seven_delta_time_us,
  output logic [tts_pkg::TTS_US_W-1:0]         seg_eight_delta_time_us,
  output logic [tts_pkg::TTS_US_W-1:0]         seg_nine_delta_time_us,
  output logic [tts_pkg::TTS_US_W-1:0]         seg_ten_delta_time_us,
  output logic [tts_pkg::TTS_CYC_W-1:0]        seg_seven_delta_time_cyc,
  output logic [tts_pkg::TTS_CYC_W-1:0]        seg_eight_delta_time_cyc,
  output logic [tts_pkg::TTS_CYC_W-1:0]        seg_nine_delta_time_cyc,
  output logic [tts_pkg::TTS_CYC_W-1:0]        seg_ten_delta_time_cyc,
  output logic                                 cfg_three_written,
  output logic                                 cfg_four_written
);
  import tts_pkg::*;

  typedef struct packed {
    logic                                 awready;
    logic                                 wready;
    logic                                 arready;
    logic                                 bvalid;
    logic                                 rvalid;
    logic [1:0]                           bresp;
    logic [1:0]                           rresp;
    logic                                 aw_have;
    logic                                 w_have;
    logic [TTS_AXI_AW-1:0]                aw_addr;
    logic [TTS_REG_W-1:0]                 w_data;
    logic                                 w_lane0;
    logic [TTS_REG_W-1:0]                 rdata;
    logic [TTS_REG_W-1:0]                 cfg_three;
    logic [TTS_REG_W-1:0]                 cfg_four;
    logic                                 written_three;
    logic                                 written_four;
    logic [TTS_NSEG-1:0][TTS_US_W-1:0]    time_us;
    logic [TTS_NSEG-1:0][TTS_CYC_W-1:0]   time_cyc;
  } tts_state_s;

  tts_state_s s_q;
  tts_state_s s_d;

  logic [TTS_NSEG-1:0][TTS_CODE_W-1:0] seg_code;
  logic [TTS_NSEG-1:0][TTS_US_W-1:0]   lut_us;
  logic [TTS_NSEG-1:0][TTS_CYC_W-1:0]  lut_cyc;
  logic [TTS_NSEG-1:0]                 seg_written;
  logic                                wr_fire;
  logic                                wr_sel_three;
  logic                                wr_sel_four;
  logic                                rd_fire;
  logic                                rd_sel_three;
  logic                                rd_sel_four;

  // field extraction; segment order seven, eight, nine, ten
  assign seg_code[0] = s_q.cfg_three[TTS_HI_FIELD_LSB +: TTS_CODE_W];
  assign seg_code[1] = s_q.cfg_three[TTS_LO_FIELD_LSB +: TTS_CODE_W];
  assign seg_code[2] = s_q.cfg_four[TTS_HI_FIELD_LSB +: TTS_CODE_W];
  assign seg_code[3] = s_q.cfg_four[TTS_LO_FIELD_LSB +: TTS_CODE_W];
  assign seg_written = {s_q.written_four, s_q.written_four,
                        s_q.written_three, s_q.written_three};

  genvar gi;
  generate
    for (gi = 0; gi < TTS_NSEG; gi++) begin : g_seg
      tts_time_lut u_lut (
        .code     (seg_code[gi]),
        .time_us  (lut_us[gi]),
        .time_cyc (lut_cyc[gi])
      );
    end
  endgenerate

  // decode ignores the two byte-offset bits; word granularity only
  assign wr_sel_three = s_q.aw_addr[TTS_AXI_AW-1:2] == TTS_ADDR_CFG_THREE[TTS_AXI_AW-1:2];
  assign wr_sel_four  = s_q.aw_addr[TTS_AXI_AW-1:2] == TTS_ADDR_CFG_FOUR[TTS_AXI_AW-1:2];
  assign rd_sel_three = s_axi_araddr[TTS_AXI_AW-1:2] == TTS_ADDR_CFG_THREE[TTS_AXI_AW-1:2];
  assign rd_sel_four  = s_axi_araddr[TTS_AXI_AW-1:2] == TTS_ADDR_CFG_FOUR[TTS_AXI_AW-1:2];
  assign wr_fire      = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign rd_fire      = s_q.arready && s_axi_arvalid;

  always_comb begin
    s_d = s_q;
    // address and data are captured independently, in either order
    if (s_q.awready && s_axi_awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.w_have  = 1'b1;
      s_d.w_data  = s_axi_wdata[TTS_REG_W-1:0];
      s_d.w_lane0 = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // response waits for the previous one to drain, one write in flight
    if (wr_fire) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      if (wr_sel_three) begin
        s_d.bresp = TTS_RESP_OKAY;
        if (s_q.w_lane0) begin
          s_d.cfg_three     = s_q.w_data;
          s_d.written_three = 1'b1;
        end
      end else if (wr_sel_four) begin
        s_d.bresp = TTS_RESP_OKAY;
        if (s_q.w_lane0) begin
          s_d.cfg_four     = s_q.w_data;
          s_d.written_four = 1'b1;
        end
      end else begin
        s_d.bresp = TTS_RESP_SLVERR;
      end
    end
    s_d.awready = !s_d.aw_have;
    s_d.wready  = !s_d.w_have;

    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // an unwritten register reads back whatever the storage holds
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      if (rd_sel_three) begin
        s_d.rdata = s_q.cfg_three;
        s_d.rresp = TTS_RESP_OKAY;
      end else if (rd_sel_four) begin
        s_d.rdata = s_q.cfg_four;
        s_d.rresp = TTS_RESP_OKAY;
      end else begin
        s_d.rdata = TTS_RDATA_RST;
        s_d.rresp = TTS_RESP_SLVERR;
      end
    end
    s_d.arready = !s_d.rvalid;

    // consumers see zero until the host has loaded the register
    for (int i = 0; i < TTS_NSEG; i++) begin
      s_d.time_us[i]  = seg_written[i] ? lut_us[i] : TTS_US_RST;
      s_d.time_cyc[i] = seg_written[i] ? lut_cyc[i] : TTS_CYC_RST;
    end
  end

  // config storage (cfg_three, cfg_four) deliberately left out of reset: contents undefined until written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q.awready       <= 1'b0;
      s_q.wready        <= 1'b0;
      s_q.arready       <= 1'b0;
      s_q.bvalid        <= 1'b0;
      s_q.rvalid        <= 1'b0;
      s_q.bresp         <= TTS_RESP_OKAY;
      s_q.rresp         <= TTS_RESP_OKAY;
      s_q.aw_have       <= 1'b0;
      s_q.w_have        <= 1'b0;
      s_q.aw_addr       <= '0;
      s_q.w_data        <= TTS_RDATA_RST;
      s_q.w_lane0       <= 1'b0;
      s_q.rdata         <= TTS_RDATA_RST;
      s_q.written_three <= 1'b0;
      s_q.written_four  <= 1'b0;
      s_q.time_us       <= '0;
      s_q.time_cyc      <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready            = s_q.awready;
  assign s_axi_wready             = s_q.wready;
  assign s_axi_arready            = s_q.arready;
  assign s_axi_bvalid             = s_q.bvalid;
  assign s_axi_bresp              = s_q.bresp;
  assign s_axi_rvalid             = s_q.rvalid;
  assign s_axi_rresp              = s_q.rresp;
  assign s_axi_rdata              = {24'h000000, s_q.rdata};
  assign seg_seven_delta_time_us  = s_q.time_us[0];
  assign seg_eight_delta_time_us  = s_q.time_us[1];
  assign seg_nine_delta_time_us   = s_q.time_us[2];
  assign seg_ten_delta_time_us    = s_q.time_us[3];
  assign seg_seven_delta_time_cyc = s_q.time_cyc[0];
  assign seg_eight_delta_time_cyc = s_q.time_cyc[1];
  assign seg_nine_delta_time_cyc  = s_q.time_cyc[2];
  assign seg_ten_delta_time_cyc   = s_q.time_cyc[3];
  assign cfg_three_written        = s_q.written_three;
  assign cfg_four_written         = s_q.written_four;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_SEG_SEVEN_TABLE: assert property (
    (wr_fire && wr_sel_three && s_q.w_lane0 && s_q.w_data[7:4] == 4'hf)
      |=> ##1 (seg_seven_delta_time_us == 14'd8000 && seg_seven_delta_time_cyc == 20'd1000000))
    else $error("segment seven time not decoded from bits 7:4");

  AST_SEG_EIGHT_FIELD: assert property (
    (wr_fire && wr_sel_three && s_q.w_lane0 && s_q.w_data[3:0] == 4'h4)
      |=> ##1 (seg_eight_delta_time_us == 14'd600 && cfg_three_written))
    else $error("segment eight time not decoded from bits 3:0");

  AST_SEG_NINE_READ: assert property (
    (rd_fire && rd_sel_four && s_q.written_four)
      |=> (s_axi_rvalid && s_axi_rresp == TTS_RESP_OKAY
           && s_axi_rdata[7:4] == $past(s_q.cfg_four[7:4])
           && seg_nine_delta_time_us == $past(lut_us[2])))
    else $error("segment nine field readback mismatch");

  AST_SEG_TEN_WRITE: assert property (
    (wr_fire && wr_sel_four && s_q.w_lane0)
      |=> (s_q.cfg_four[3:0] == $past(s_q.w_data[3:0]) && s_axi_bvalid
           && s_axi_bresp == TTS_RESP_OKAY)
          ##1 (seg_ten_delta_time_cyc == 20'(seg_ten_delta_time_us) * 20'd125))
    else $error("segment ten field write or decode wrong");

  AST_CFG_FOUR_UNSET: assert property (
    (!s_q.written_four)
      |=> (seg_nine_delta_time_us == 14'd0 && seg_ten_delta_time_cyc == 20'd0))
    else $error("config four outputs not zero before first write");

  // lane 0 off: still answered okay, only the store is skipped
  AST_CFG_THREE_DECODE: assert property (
    (wr_fire && s_q.aw_addr == TTS_ADDR_CFG_THREE && !s_q.w_lane0 && s_q.written_three)
      |=> ($stable(s_q.cfg_three) && s_q.written_three && s_axi_bresp == TTS_RESP_OKAY)[*2])
    else $error("config three decode or lane gating wrong");

  AST_CFG_THREE_STORE: assert property (
    (wr_fire && wr_sel_three && s_q.w_lane0)
      |=> (s_q.written_three && s_q.cfg_three == $past(s_q.w_data) && s_axi_bvalid))
    else $error("config three write not stored");

  AST_CFG_FOUR_STORE: assert property (
    (wr_fire && wr_sel_four && s_q.w_lane0)
      |=> (s_q.written_four && s_q.cfg_four == $past(s_q.w_data) && s_axi_bvalid))
    else $error("config four write not stored");

  AST_READ_THREE: assert property (
    (rd_fire && rd_sel_three && s_q.written_three)
      |=> (s_axi_rvalid && s_axi_rresp == TTS_RESP_OKAY
           && s_axi_rdata == {24'h000000, $past(s_q.cfg_three)}))
    else $error("config three readback mismatch");

  // anything outside the two words is refused, not aliased
  AST_UNMAPPED_WRITE: assert property (
    (wr_fire && !wr_sel_three && !wr_sel_four)
      |=> (s_axi_bvalid && s_axi_bresp == TTS_RESP_SLVERR && $stable(s_q.written_four)))
    else $error("unmapped write not refused");

  AST_UNMAPPED_READ: assert property (
    (rd_fire && !rd_sel_three && !rd_sel_four)
      |=> (s_axi_rvalid && s_axi_rresp == TTS_RESP_SLVERR && s_axi_rdata == 32'h00000000))
    else $error("unmapped read not refused");

  AST_SEG_SEVEN_LOW: assert property (
    (s_q.written_three && s_q.cfg_three[7:4] == 4'h0)
      |=> (seg_seven_delta_time_us == 14'd100 && seg_seven_delta_time_cyc == 20'd12500))
    else $error("segment seven lowest code decoded wrong");

  AST_SEG_EIGHT_TOP: assert property (
    (s_q.written_three && s_q.cfg_three[3:0] == 4'hf)
      |=> (seg_eight_delta_time_us == 14'd8000 && seg_eight_delta_time_cyc == 20'd1000000))
    else $error("segment eight top code decoded wrong");

  AST_SEG_NINE_MID: assert property (
    (s_q.written_four && s_q.cfg_four[7:4] == 4'h9)
      |=> (seg_nine_delta_time_us == 14'd2000 && seg_nine_delta_time_cyc == 20'd250000))
    else $error("segment nine code nine decoded wrong");

  AST_SEG_TEN_MID: assert property (
    (s_q.written_four && s_q.cfg_four[3:0] == 4'h5)
      |=> (seg_ten_delta_time_us == 14'd800 && seg_ten_delta_time_cyc == 20'd100000))
    else $error("segment ten code five decoded wrong");

  AST_CFG_THREE_UNSET: assert property (
    (!s_q.written_three)
      |=> (seg_seven_delta_time_us == 14'd0 && seg_eight_delta_time_cyc == 20'd0))
    else $error("config three outputs not zero before first write");

endmodule

// ---- tts_regs_bench.sv ----
`timescale 1ns/1ps
module tts_regs_bench;
  import tts_pkg::*;
  logic                  aclk;
  logic                  aresetn;
  logic [TTS_AXI_AW-1:0] awaddr;
  logic [TTS_AXI_AW-1:0] araddr;
  logic [TTS_AXI_DW-1:0] wdata;
  logic [TTS_AXI_DW-1:0] rdata;
  logic [3:0]            wstrb;
  logic [1:0]            bresp;
  logic [1:0]            rresp;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready, wr3, wr4;
  logic [TTS_US_W-1:0]   us_o [4];
  logic [TTS_CYC_W-1:0]  cyc_o [4];
  logic [31:0]           rd;
  logic [1:0]            rsp;
  int                    err_count, cmp_count;
  // own copy of the time table, so a wrong package entry shows up
  int                    tab [16] = '{100, 200, 300, 400, 600, 800, 1000, 1200,
                                      1400, 2000, 2400, 3200, 4000, 5200, 6400, 8000};

  tts_regs dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .seg_seven_delta_time_us(us_o[0]), .seg_eight_delta_time_us(us_o[1]),
    .seg_nine_delta_time_us(us_o[2]), .seg_ten_delta_time_us(us_o[3]),
    .seg_seven_delta_time_cyc(cyc_o[0]), .seg_eight_delta_time_cyc(cyc_o[1]),
    .seg_nine_delta_time_cyc(cyc_o[2]), .seg_ten_delta_time_cyc(cyc_o[3]),
    .cfg_three_written(wr3), .cfg_four_written(wr4)
  );

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic stop_test;
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // handshakes judged at the negedge before the edge: ready is registered, so it is settled
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int n;
    logic haw, hw, hb;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      haw = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (haw) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      err_count++;
      stop_test();
    end
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic har, hr;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      har = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (har) arvalid <= 1'b0;
      if (hr) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      err_count++;
      stop_test();
    end
  endtask

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic chk_seg(input int i, input int k);
    check(32'(us_o[i]), 32'(tab[k]));
    check(32'(cyc_o[i]), 32'(tab[k] * TTS_CYC_PER_US));
  endtask

  initial begin
    aresetn = 1'b0;
    awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = 4'h0; wvalid = 1'b0; bready = 1'b0;
    araddr = '0; arvalid = 1'b0; rready = 1'b0;
    err_count = 0;
    cmp_count = 0;
    do_reset();
    check(32'({wr3, wr4}), 32'h0);
    check(32'(us_o[3]), 32'h0);
    // every code through every field, both registers written first each round
    for (int k = 0; k < 16; k++) begin
      axi_write(TTS_ADDR_CFG_THREE, 32'({k[3:0], 4'(15 - k)}), 4'h1, rsp);
      check(32'(rsp), 32'(TTS_RESP_OKAY));
      axi_write(TTS_ADDR_CFG_FOUR, 32'({4'(15 - k), k[3:0]}), 4'h1, rsp);
      check(32'(rsp), 32'(TTS_RESP_OKAY));
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk_seg(0, k);
      chk_seg(1, 15 - k);
      chk_seg(2, 15 - k);
      chk_seg(3, k);
      axi_read(TTS_ADDR_CFG_THREE, rd, rsp);
      check(rd, 32'({k[3:0], 4'(15 - k)}));
      axi_read(TTS_ADDR_CFG_FOUR, rd, rsp);
      check(rd, 32'({4'(15 - k), k[3:0]}));
    end
    check(32'({wr3, wr4}), 32'h3);
    // lane 0 disabled: accepted but nothing stored
    axi_write(TTS_ADDR_CFG_THREE, 32'h0000005a, 4'he, rsp);
    check(32'(rsp), 32'(TTS_RESP_OKAY));
    axi_read(TTS_ADDR_CFG_THREE, rd, rsp);
    check(rd, 32'h000000f0);
    // next index up is outside this bank
    axi_write(12'h190, 32'h000000a5, 4'hf, rsp);
    check(32'(rsp), 32'(TTS_RESP_SLVERR));
    axi_read(12'h190, rd, rsp);
    check(32'(rsp), 32'(TTS_RESP_SLVERR));
    check(rd, 32'h0);
    axi_read(TTS_ADDR_CFG_FOUR, rd, rsp);
    check(rd, 32'h0000000f);
    // storage has no reset value, so a mid-run reset leaves it alone
    do_reset();
    @(negedge aclk);
    check(32'({wr3, wr4}), 32'h0);
    check(32'(us_o[0]), 32'h0);
    axi_read(TTS_ADDR_CFG_THREE, rd, rsp);
    check(rd, 32'h000000f0);
    check(32'(rsp), 32'(TTS_RESP_OKAY));
    stop_test();
  end
endmodule
